// File: inc/sio_pkg.sv
// package: function codes, widths and reset values for safety io assignment
package sio_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_IN   = 4;
    localparam int unsigned NUM_OUT  = 4;
    localparam int unsigned CODE_W   = 5;
    localparam int unsigned NUM_CMD  = 11;
    localparam int unsigned NUM_STAT = 14;

    // ------------------------------------------------------------
    // input function codes
    // ------------------------------------------------------------
    localparam logic [4:0] IN_TORQUE_OFF     = 5'h01;
    localparam logic [4:0] IN_SPEED_LIMIT_4  = 5'h08;
    localparam logic [4:0] IN_FORWARD_INHIB  = 5'h09;
    localparam logic [4:0] IN_REVERSE_INHIB  = 5'h0a;
    localparam logic [4:0] IN_ACKNOWLEDGE    = 5'h0b;

    // ------------------------------------------------------------
    // output function codes
    // ------------------------------------------------------------
    localparam logic [4:0] OUT_FIRST         = 5'h01;
    localparam logic [4:0] OUT_LAST          = 5'h0e;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [10:0] CMD_RESET        = 11'h000;
    localparam logic [3:0]  OUT_RESET        = 4'h0;
    localparam logic [1:0]  SYNC_RESET       = 2'h3;

    // trigger modes
    typedef enum logic {
        SIO_MODE_LOCAL = 1'b0,
        SIO_MODE_BUS   = 1'b1
    } sio_mode_t;

endpackage : sio_pkg

// File: sim/sio_assign_asserts.sv
// checker for safety io function assignment
`timescale 1ns/1ps
module sio_assign_asserts
(
    input wire logic               clock,
    input wire logic               rst_n,
    input wire sio_pkg::sio_mode_t trigger_mode,
    input wire logic [3:0]         safety_input,
    input wire logic [19:0]        in_code,
    input wire logic [19:0]        out_code,
    input wire logic [13:0]        function_state,
    input wire logic [10:0]        command_request,
    input wire logic [3:0]         safety_output,
    input wire logic               diag_enable
);
    import sio_pkg::*;
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire       loc = rst_n && trigger_mode == SIO_MODE_LOCAL;
    wire [4:0] oc = out_code[4:0];
    property p_bus; $past(trigger_mode) == SIO_MODE_BUS |->
        command_request == 11'h0 && safety_output == 4'h0 && !diag_enable;
    endproperty
    a_bus: assert property (p_bus) else $error("bus not masked");
    property p_diag; $past(loc) |-> diag_enable; endproperty
    a_diag: assert property (p_diag) else $error("diag off");
    property p_omap; $past(loc && oc >= OUT_FIRST && oc <= OUT_LAST) |->
        safety_output[0] == $past(function_state[oc - 5'h01]); endproperty
    a_omap: assert property (p_omap) else $error("out map");
    property p_obad; $past(oc == 5'h00 || oc > OUT_LAST) |->
        !safety_output[0]; endproperty
    a_obad: assert property (p_obad) else $error("bad out");
    property p_inone; $past(in_code == 20'h0) |->
        command_request == 11'h0; endproperty
    a_inone: assert property (p_inone) else $error("bad in");
    property p_stop; (loc && in_code == {4{IN_TORQUE_OFF}} &&
        safety_input == 4'h0)[*4] |=> command_request == 11'h001; endproperty
    a_stop: assert property (p_stop) else $error("low req");
    property p_fwd; (loc && in_code == {4{IN_FORWARD_INHIB}} &&
        safety_input == 4'hf)[*4] |=> command_request == 11'h000; endproperty
    a_fwd: assert property (p_fwd) else $error("inhibit");
    property p_ack; (loc && in_code == {4{IN_ACKNOWLEDGE}} &&
        safety_input == 4'hf)[*4] |=> command_request == 11'h400; endproperty
    a_ack: assert property (p_ack) else $error("ack");
endmodule : sio_assign_asserts
bind sio_assign sio_assign_asserts i_chk (
    .clock           (clock),
    .rst_n           (rst_n),
    .trigger_mode    (trigger_mode),
    .safety_input    (safety_input),
    .in_code         (in_code),
    .out_code        (out_code),
    .function_state  (function_state),
    .command_request (command_request),
    .safety_output   (safety_output),
    .diag_enable     (diag_enable)
);

// File: sim/sio_switch_model.sv
// model of the external safety switches
`timescale 1ns/1ps
module sio_switch_model
(
    input  wire logic [3:0] level,
    output logic      [3:0] pin
);
    // contacts wired straight, no bounce, to keep runs short
    assign pin = level;
endmodule : sio_switch_model

// File: sim/tb.sv
// testbench for safety io function assignment
`timescale 1ns/1ps
module tb;
    import sio_pkg::*;
    // ------------------------------------------------------------
    // bench
    // ------------------------------------------------------------
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    sio_mode_t   trigger_mode = SIO_MODE_LOCAL;
    logic [3:0]  level = 4'hf;
    logic [3:0]  safety_input;
    logic [19:0] in_code = 20'h0;
    logic [19:0] out_code = 20'h0;
    logic [13:0] function_state = 14'h0;
    logic [10:0] command_request;
    logic [3:0]  safety_output;
    logic        diag_enable;
    int          miscompares = 0;
    int          checked = 0;
    int          cycles = 0;
    sio_switch_model i_sw (.level(level), .pin(safety_input));
    sio_assign i_dut (.clock(clock), .rst_n(rst_n),
        .trigger_mode(trigger_mode), .safety_input(safety_input),
        .in_code(in_code), .out_code(out_code),
        .function_state(function_state), .command_request(command_request),
        .safety_output(safety_output), .diag_enable(diag_enable));
    initial forever #12.5 clock = ~clock;
    task automatic check(input string nm, input logic [10:0] sn, ex);
        checked++;
        if (sn !== ex)
        begin
            miscompares++;
            $display("[FAIL] %s exp %h seen %h", nm, ex, sn);
        end
    endtask : check
    task automatic t_inputs;
        logic [10:0] ex;
        for (int c = 0; c < 32; c++)
            for (int lv = 0; lv < 2; lv++)
            begin
                in_code = {4{c[4:0]}};
                level = {4{lv[0]}};
                repeat (5) @(negedge clock);
                ex = 11'h0;
                if (c >= 1 && c <= 11)
                    ex[c-1] = (c == 11) ? lv[0] : !lv[0];
                check("cmd", command_request, ex);
            end
    endtask : t_inputs
    task automatic t_outputs;
        logic [3:0] ex;
        int         k;
        logic [19:0] oc;
        for (int c = 0; c < 32; c++)
        begin
            for (int j = 0; j < 4; j++)
                oc[5*j +: 5] = 5'((c + j) % 32);
            // one assignment per output per step
            function_state = c[0] ? 14'h2a5b : 14'h15a4;
            out_code = oc;
            repeat (2) @(negedge clock);
            for (int j = 0; j < 4; j++)
            begin
                k = (c + j) % 32;
                ex[j] = (k >= 1 && k <= 14) ? function_state[k-1] : 1'b0;
            end
            check("out", 11'(safety_output), 11'(ex));
            check("diag", 11'(diag_enable), 11'h1);
        end
    endtask : t_outputs
    task automatic t_mixed;
        // two inputs share code 01: either one low requests it
        in_code = {IN_ACKNOWLEDGE, 5'h03, IN_TORQUE_OFF, IN_TORQUE_OFF};
        level = 4'ha;
        repeat (5) @(negedge clock);
        check("mix a", command_request, 11'h405);
        level = 4'h5;
        repeat (5) @(negedge clock);
        check("mix b", command_request, 11'h001);
        level = 4'hb;
        repeat (5) @(negedge clock);
        check("mix c", command_request, 11'h404);
    endtask : t_mixed
    task automatic t_reset;
        in_code = {4{IN_TORQUE_OFF}};
        level = 4'h0;
        rst_n = 1'b0;
        repeat (3) @(negedge clock);
        check("rst cmd", command_request, 11'h0);
        check("rst out", 11'(safety_output), 11'h0);
        check("rst diag", 11'(diag_enable), 11'h0);
        rst_n = 1'b1;
        repeat (2) @(negedge clock);
        // synchronisers restart deselected, so the request lags release
        check("rel cmd", command_request, 11'h0);
        repeat (2) @(negedge clock);
        check("run cmd", command_request, 11'h001);
    endtask : t_reset
    task automatic t_bus;
        trigger_mode = SIO_MODE_BUS;
        level = 4'h0;
        in_code = {4{IN_TORQUE_OFF}};
        out_code = {4{OUT_FIRST}};
        function_state = 14'h0001;
        repeat (5) @(negedge clock);
        check("bus cmd", command_request, 11'h0);
        check("bus out", 11'(safety_output), 11'h0);
        check("bus diag", 11'(diag_enable), 11'h0);
        // same stimulus back in local mode must reach the pins again
        trigger_mode = SIO_MODE_LOCAL;
        repeat (2) @(negedge clock);
        check("loc cmd", command_request, 11'h001);
        check("loc out", 11'(safety_output), 11'h00f);
        check("loc diag", 11'(diag_enable), 11'h1);
    endtask : t_bus
    task automatic results;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results
    // hang guard, well above the few hundred cycles the scenarios need
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            results();
        end
    end
    initial
    begin
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        t_inputs();
        t_mixed();
        t_outputs();
        t_reset();
        t_bus();
        results();
    end
endmodule : tb

// File: src/sio_assign.sv
// safety digital input and output function assignment
`timescale 1ns/1ps

module sio_assign
(
    input  wire logic                                  clock,
    input  wire logic                                  rst_n,
    input  wire sio_pkg::sio_mode_t                    trigger_mode,
    input  wire logic [sio_pkg::NUM_IN-1:0]            safety_input,
    input  wire logic [sio_pkg::NUM_IN*sio_pkg::CODE_W-1:0]  in_code,
    input  wire logic [sio_pkg::NUM_OUT*sio_pkg::CODE_W-1:0] out_code,
    input  wire logic [sio_pkg::NUM_STAT-1:0]          function_state,
    output logic [sio_pkg::NUM_CMD-1:0]                command_request,
    output logic [sio_pkg::NUM_OUT-1:0]                safety_output,
    output logic                                       diag_enable
);
    import sio_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [NUM_IN-1:0] in_sync;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++)
        begin : g_sync
            sio_sync u_sync
            (
                .clock    (clock),
                .rst_n    (rst_n),
                .pin_in   (safety_input[gi]),
                .pin_sync (in_sync[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    // each input raises at most one bit of its own request vector
    logic [NUM_CMD-1:0] in_req [NUM_IN];

    generate
        for (gi = 0; gi < NUM_IN; gi++)
        begin : g_in_dec
            always_comb
            begin
                logic [CODE_W-1:0] code;
                logic [3:0]        slot;
                logic              req;
                code       = in_code[gi*CODE_W +: CODE_W];
                slot       = 4'(code - IN_TORQUE_OFF);
                req        = 1'b0;
                in_req[gi] = CMD_RESET;
                if (code >= IN_TORQUE_OFF && code <= IN_SPEED_LIMIT_4)
                    req = ~in_sync[gi];
                else if (code == IN_FORWARD_INHIB)
                    req = ~in_sync[gi];
                else if (code == IN_REVERSE_INHIB)
                    req = ~in_sync[gi];
                else if (code == IN_ACKNOWLEDGE)
                    req = in_sync[gi];
                else
                    req = 1'b0;
                if (code >= IN_TORQUE_OFF && code <= IN_ACKNOWLEDGE)
                    in_req[gi][slot] = req;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // command merge
    // ------------------------------------------------------------
    logic [NUM_CMD-1:0] req_any;
    logic               torque_off;
    logic               brake_control;
    logic               stop_type_one;
    logic               stop_type_two;
    logic               speed_limit_one;
    logic               speed_limit_two;
    logic               speed_limit_three;
    logic               speed_limit_four;
    logic               forward_direction_inhibit;
    logic               reverse_direction_inhibit;
    logic               fault_acknowledge;

    // several inputs on one code combine: any request wins
    always_comb
    begin
        req_any = CMD_RESET;
        for (int i = 0; i < NUM_IN; i++)
            req_any = req_any | in_req[i];
    end

    // one name per command, code 11 first down to code 01
    assign {fault_acknowledge,
            reverse_direction_inhibit,
            forward_direction_inhibit,
            speed_limit_four,
            speed_limit_three,
            speed_limit_two,
            speed_limit_one,
            stop_type_two,
            stop_type_one,
            brake_control,
            torque_off} = req_any;

    // ------------------------------------------------------------
    // command register
    // ------------------------------------------------------------
    // command_request bit k-1 is the request for input code k, active high
    logic [NUM_CMD-1:0] cmd_reg;
    logic [NUM_CMD-1:0] cmd_next;

    always_comb
    begin
        cmd_next = {fault_acknowledge,
                    reverse_direction_inhibit,
                    forward_direction_inhibit,
                    speed_limit_four,
                    speed_limit_three,
                    speed_limit_two,
                    speed_limit_one,
                    stop_type_two,
                    stop_type_one,
                    brake_control,
                    torque_off};
        // bus mode drops every local request before it is registered
        if (trigger_mode != SIO_MODE_LOCAL)
            cmd_next = CMD_RESET;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            cmd_reg <= CMD_RESET;
        else
            cmd_reg <= cmd_next;
    end

    assign command_request = cmd_reg;

    // ------------------------------------------------------------
    // output decode
    // ------------------------------------------------------------
    // function_state bit k-1 is the state for output code k; the
    // meaning of each level per code is produced upstream
    logic               out_sel [NUM_OUT];
    logic [NUM_OUT-1:0] out_reg;
    logic [NUM_OUT-1:0] out_next;

    generate
        for (gi = 0; gi < NUM_OUT; gi++)
        begin : g_out_dec
            always_comb
            begin
                logic [CODE_W-1:0] ocode;
                logic [3:0]        slot;
                ocode = out_code[gi*CODE_W +: CODE_W];
                slot  = 4'(ocode - OUT_FIRST);
                if (ocode >= OUT_FIRST && ocode <= OUT_LAST)
                    out_sel[gi] = function_state[slot];
                else
                    out_sel[gi] = 1'b0;
            end
        end
    endgenerate

    always_comb
    begin
        out_next = OUT_RESET;
        for (int j = 0; j < NUM_OUT; j++)
            out_next[j] = out_sel[j];
        if (trigger_mode != SIO_MODE_LOCAL)
            out_next = OUT_RESET;
    end

    // outputs registered: one cycle latency buys glitch-free pins
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            out_reg <= OUT_RESET;
        else
            out_reg <= out_next;
    end

    assign safety_output = out_reg;

    // ------------------------------------------------------------
    // diagnosis gate
    // ------------------------------------------------------------
    // low through reset, so no circuit test starts before the mode
    // has been sampled once
    logic               diag_reg;
    logic               diag_next;

    always_comb
    begin
        diag_next = (trigger_mode == SIO_MODE_LOCAL);
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            diag_reg <= 1'b0;
        else
            diag_reg <= diag_next;
    end

    assign diag_enable = diag_reg;

endmodule : sio_assign

// File: src/sio_sync.sv
// two-flop synchroniser for one pin
`timescale 1ns/1ps

module sio_sync
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic pin_in,
    output logic      pin_sync
);
    import sio_pkg::*;

    logic [1:0] stage_reg;
    logic [1:0] stage_next;

    always_comb
    begin
        stage_next = {stage_reg[0], pin_in};
    end

    // resets high: an idle input reads as deselected for low-active codes
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            stage_reg <= SYNC_RESET;
        else
            stage_reg <= stage_next;
    end

    assign pin_sync = stage_reg[1];

endmodule : sio_sync
